// ==== core/rox_pkg.sv ====
// Constants, register map and carrier types of the reflex output compare block.
// Assumes a single 200 MHz clock domain and an AXI4-Lite master with 8-bit addresses.
package rox_pkg;
	localparam int unsigned ROX_ADDR_W = 8;
	localparam int unsigned ROX_MS_NS = 1_000_000;
	localparam int unsigned ROX_CLK_NS = 5;
	localparam int unsigned ROX_MS_CYCLES = ROX_MS_NS / ROX_CLK_NS;
	localparam logic [7:0] ROX_REG_CTRL = 8'h00;
	localparam logic [7:0] ROX_REG_GATE = 8'h04;
	localparam logic [7:0] ROX_REG_REFL = 8'h08;
	localparam logic [7:0] ROX_REG_ABOVE = 8'h0C;
	localparam logic [7:0] ROX_REG_DRV = 8'h10;
	localparam logic [7:0] ROX_REG_IRQ_ST = 8'h14;
	localparam logic [7:0] ROX_REG_IRQ_MASK = 8'h18;
	localparam logic [3:0] ROX_REG_CFG_PAGE = 4'h2;
	localparam logic [3:0] ROX_REG_LVL_PAGE = 4'h4;
	localparam int unsigned ROX_CTRL_EN_BIT = 0;
	localparam int unsigned ROX_CTRL_SUS_BIT = 1;
	localparam logic [31:0] ROX_CFG_WMASK = 32'hFFFF_0FFF;
	localparam logic [2:0] ROX_COND_OFF = 3'h0;
	localparam logic [2:0] ROX_COND_WITHIN = 3'h1;
	localparam logic [2:0] ROX_COND_CROSS = 3'h2;
	localparam logic [2:0] ROX_COND_CAPTURE = 3'h3;
	localparam logic [2:0] ROX_COND_STOP = 3'h4;
	localparam logic [15:0] ROX_DUR_RESET = 16'h000A;
	localparam logic [1:0] ROX_RESP_OKAY = 2'h0;
	localparam logic [1:0] ROX_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [ROX_ADDR_W-1:0] awaddr;
		logic                  awvalid;
		logic [31:0]           wdata;
		logic [3:0]            wstrb;
		logic                  wvalid;
		logic                  bready;
		logic [ROX_ADDR_W-1:0] araddr;
		logic                  arvalid;
		logic                  rready;
	} rox_axil_req_type;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} rox_axil_rsp_type;

	// Per-output configuration word, laid out as it reads on the bus.
	typedef struct packed {
		logic [15:0] dur;
		logic [3:0]  rsvd;
		logic        run_sel;
		logic        up;
		logic [1:0]  th_sel;
		logic [4:0]  zone;
		logic [2:0]  cond;
	} rox_cfg_type;

	typedef struct packed {
		rox_axil_rsp_type      rsp;
		logic                  aw_got;
		logic                  w_got;
		logic [ROX_ADDR_W-1:0] awaddr;
		logic [31:0]           wdata;
		logic [3:0]            wstrb;
		logic                  ctrl_en;
		logic                  ctrl_sus;
		logic [3:0]            gate;
		rox_cfg_type [3:0]     cfg;
		logic [3:0][31:0]      stage;
		logic [3:0][31:0]      lvl;
		logic                  preset_prev;
		logic [3:0]            above;
		logic [3:0]            refl;
		logic [3:0]            drv;
		logic [3:0][15:0]      timer;
		logic [3:0][23:0]      sub;
		logic [3:0]            irq_st;
		logic [3:0]            irq_mask;
		logic                  irq;
	} rox_state_type;
endpackage

// ==== core/rox_top.sv ====
// Reflex output compare block: four thresholds, four reflex outputs, AXI4-Lite registers.
// Assumes counter value, capture value, run and preset inputs come from logic on ref_clk.
// Summary of operation
// - Each output in crossing mode picks one of four levels and a direction, downward on level 0 by default.
// - Upward selection fires on a rise of the chosen above-level bit.
// - Downward selection fires on a fall of the chosen above-level bit.
// - A crossing trigger holds the output true for 1 to 65535 ms, 10 ms by default.
// - Stop mode, the default, makes the output true while the counter is stopped.
// - Run mode makes the output true while the counter run indication is high.
// - Newly written levels become active only on a rising edge of the preset condition.
// - Bits 0 to 3 of a read-only byte report each output's evaluated condition.
// - Bits 0 to 3 of a read-only byte report counter strictly above each level.
// - Outside suspension, a physical output is driven only when its enable bit and its condition bit are both true.
// - Bits 0 to 3 of a read-only byte report which physical outputs are driven.
// - Within mode uses a five-bit zone mask over the counter: below level 0, between pairs, above level 3.
// - Capture-within mode applies the same zone mask to the captured value.
// - While comparison is suspended the above-level bits hold, and so do the condition and drive bits outside crossing mode.
// - A pulse running at suspension completes its duration and then drops.
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module rox_top #(
	parameter int unsigned MS_CYCLES = rox_pkg::ROX_MS_CYCLES
) (
	input  wire logic                     ref_clk,
	input  wire logic                     srst,
	input  wire logic                     clk_en,
	input  wire rox_pkg::rox_axil_req_type axil_req,
	output var  rox_pkg::rox_axil_rsp_type axil_rsp,
	input  wire logic [31:0]              counter_value,
	input  wire logic [31:0]              capture_value,
	input  wire logic                     counter_running,
	input  wire logic                     preset_cond,
	output logic [3:0]                    phys_out,
	output logic                          irq
);
	import rox_pkg::*;

	rox_state_type s;
	rox_state_type d;
	logic [3:0]       ab_now;
	logic [3:0]       cab_now;
	logic [3:0]       trig;
	logic [3:0][15:0] dur_eff;

	assign axil_rsp = s.rsp;
	assign phys_out = s.drv;
	assign irq = s.irq;

	// Zone membership of a value from its above-level bits.
	function automatic logic [4:0] zones(input logic [3:0] ab);
		zones = {ab[3], ab[2] & ~ab[3], ab[1] & ~ab[2], ab[0] & ~ab[1], ~ab[0]};
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] st);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				r[b*8 +: 8] = n[b*8 +: 8];
			end
		end
		merge = r;
	endfunction

	// Bit 32 flags a mapped address; bits 31:0 are the read value.
	function automatic logic [32:0] reg_read(input logic [7:0] a, input rox_state_type st);
		logic [32:0] r;
		r = {1'b0, 32'h0000_0000};
		case (a)
			ROX_REG_CTRL: r = {1'b1, 30'h0000_0000, st.ctrl_sus, st.ctrl_en};
			ROX_REG_GATE: r = {1'b1, 28'h000_0000, st.gate};
			ROX_REG_REFL: r = {1'b1, 28'h000_0000, st.refl};
			ROX_REG_ABOVE: r = {1'b1, 28'h000_0000, st.above};
			ROX_REG_DRV: r = {1'b1, 28'h000_0000, st.drv};
			ROX_REG_IRQ_ST: r = {1'b1, 28'h000_0000, st.irq_st};
			ROX_REG_IRQ_MASK: r = {1'b1, 28'h000_0000, st.irq_mask};
			default: begin
				if (a[7:4] == ROX_REG_CFG_PAGE && a[1:0] == 2'h0) begin
					r = {1'b1, st.cfg[a[3:2]]};
				end else if (a[7:4] == ROX_REG_LVL_PAGE && a[1:0] == 2'h0) begin
					r = {1'b1, st.stage[a[3:2]]};
				end
			end
		endcase
		reg_read = r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	for (genvar g = 0; g < 4; g++) begin : g_cmp
		assign ab_now[g] = $signed(counter_value) > $signed(s.lvl[g]);
		assign cab_now[g] = $signed(capture_value) > $signed(s.lvl[g]);
		// A zero duration would never raise the output, so it is stretched to one millisecond.
		assign dur_eff[g] = (s.cfg[g].dur == 16'h0000) ? 16'h0001 : s.cfg[g].dur;
		// Edge of the chosen above-level bit against its last reported value.
		assign trig[g] = s.ctrl_en & ~s.ctrl_sus & (s.cfg[g].cond == ROX_COND_CROSS)
			& (s.cfg[g].up ? (ab_now[s.cfg[g].th_sel] & ~s.above[s.cfg[g].th_sel])
			: (~ab_now[s.cfg[g].th_sel] & s.above[s.cfg[g].th_sel]));
	end

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [32:0] rd;
		logic [31:0] wv;
		logic [3:0]  clr;
		logic [7:0]  wa;
		rd = {1'b0, 32'h0000_0000};
		wv = 32'h0000_0000;
		clr = 4'h0;
		wa = 8'h00;
		d = s;
		// Bus write side: address and data may arrive in either order.
		// Byte lanes are merged into the current value, so a partial write keeps the other bytes, except at ROX_REG_IRQ_ST where an unstrobed byte 0 clears every set bit.
		if (s.rsp.bvalid && axil_req.bready) begin
			d.rsp.bvalid = 1'b0;
		end
		if (axil_req.awvalid && s.rsp.awready) begin
			d.aw_got = 1'b1;
			d.awaddr = axil_req.awaddr;
		end
		if (axil_req.wvalid && s.rsp.wready) begin
			d.w_got = 1'b1;
			d.wdata = axil_req.wdata;
			d.wstrb = axil_req.wstrb;
		end
		if (d.aw_got && d.w_got && !d.rsp.bvalid) begin
			wa = d.awaddr;
			rd = reg_read(wa, s);
			wv = merge(rd[31:0], d.wdata, d.wstrb);
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.rsp.bvalid = 1'b1;
			d.rsp.bresp = rd[32] ? ROX_RESP_OKAY : ROX_RESP_SLVERR;
			case (wa)
				ROX_REG_CTRL: begin
					d.ctrl_en = wv[ROX_CTRL_EN_BIT];
					d.ctrl_sus = wv[ROX_CTRL_SUS_BIT];
				end
				ROX_REG_GATE: d.gate = wv[3:0];
				ROX_REG_IRQ_ST: clr = wv[3:0];
				ROX_REG_IRQ_MASK: d.irq_mask = wv[3:0];
				default: begin
					if (wa[7:4] == ROX_REG_CFG_PAGE && wa[1:0] == 2'h0) begin
						d.cfg[wa[3:2]] = rox_cfg_type'(wv & ROX_CFG_WMASK);
					end else if (wa[7:4] == ROX_REG_LVL_PAGE && wa[1:0] == 2'h0) begin
						d.stage[wa[3:2]] = wv;
					end
				end
			endcase
		end
		d.rsp.awready = !d.aw_got && !d.rsp.bvalid;
		d.rsp.wready = !d.w_got && !d.rsp.bvalid;
		// Bus read side: one read in flight, answered the cycle after the address.
		// Unmapped addresses answer with an error and read zero; read-only words take writes and ignore them.
		if (s.rsp.rvalid && axil_req.rready) begin
			d.rsp.rvalid = 1'b0;
		end
		if (axil_req.arvalid && s.rsp.arready) begin
			rd = reg_read(axil_req.araddr, s);
			d.rsp.rvalid = 1'b1;
			d.rsp.rdata = rd[31:0];
			d.rsp.rresp = rd[32] ? ROX_RESP_OKAY : ROX_RESP_SLVERR;
		end
		d.rsp.arready = !d.rsp.rvalid;
		// Active levels move only on a preset rise, so a half-written set never compares.
		d.preset_prev = preset_cond;
		if (preset_cond && !s.preset_prev) begin
			d.lvl = s.stage;
		end
		// Compare core.
		// Switching compare off clears the above, condition and drive bits and every timer at once, so no stale pulse survives.
		if (!s.ctrl_en) begin
			d.above = 4'h0;
			d.refl = 4'h0;
			d.drv = 4'h0;
			d.timer = '0;
			d.sub = '0;
		end else begin
			if (!s.ctrl_sus) begin
				d.above = ab_now;
			end
			for (int i = 0; i < 4; i++) begin
				// Pulse timer keeps running under suspension so a pulse always ends on time.
				// Each output has its own millisecond prescaler, so pulses started in different cycles end apart.
				if (trig[i]) begin
					d.timer[i] = dur_eff[i];
					d.sub[i] = 24'h00_0000;
				end else if (s.timer[i] != 16'h0000) begin
					if (s.sub[i] == 24'(MS_CYCLES - 1)) begin
						d.sub[i] = 24'h00_0000;
						d.timer[i] = s.timer[i] - 16'h0001;
					end else begin
						d.sub[i] = s.sub[i] + 24'h00_0001;
					end
				end
				if (s.cfg[i].cond == ROX_COND_CROSS) begin
					d.refl[i] = d.timer[i] != 16'h0000;
				end else if (!s.ctrl_sus) begin
					case (s.cfg[i].cond)
						ROX_COND_WITHIN: d.refl[i] = |(s.cfg[i].zone & zones(ab_now));
						ROX_COND_CAPTURE: d.refl[i] = |(s.cfg[i].zone & zones(cab_now));
						ROX_COND_STOP: d.refl[i] = s.cfg[i].run_sel ? counter_running : !counter_running;
						default: d.refl[i] = 1'b0;
					endcase
				end
			end
			if (s.ctrl_sus) begin
				d.drv = s.drv & d.refl;
			end else begin
				d.drv = s.gate & d.refl;
			end
		end
		// A new event in the clearing cycle survives the write-one-to-clear.
		// Set wins over a clear in the same cycle, so a rise is never lost.
		d.irq_st = (s.irq_st & ~clr) | (d.refl & ~s.refl);
		d.irq = |(d.irq_st & d.irq_mask);
		if (srst) begin
			d = '0;
			for (int i = 0; i < 4; i++) begin
				d.cfg[i].dur = ROX_DUR_RESET;
			end
			d.rsp.awready = 1'b1;
			d.rsp.wready = 1'b1;
			d.rsp.arready = 1'b1;
		end
	end

	// Reset is let through with the enable low, so a frozen block can still be brought to a known state.
	always_ff @(posedge ref_clk) begin
		if (srst || clk_en) begin
			s <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst || !clk_en);

	sequence s_run_cmp;
		s.ctrl_en && !s.ctrl_sus;
	endsequence
	sequence s_edge_up0;
		s_run_cmp ##0 s.cfg[0].cond == ROX_COND_CROSS && s.cfg[0].up
			&& !s.above[s.cfg[0].th_sel] && ab_now[s.cfg[0].th_sel];
	endsequence
	sequence s_edge_dn0;
		s_run_cmp ##0 s.cfg[0].cond == ROX_COND_CROSS && !s.cfg[0].up
			&& s.above[s.cfg[0].th_sel] && !ab_now[s.cfg[0].th_sel];
	endsequence
	sequence s_last_ms0;
		s.ctrl_en && s.cfg[0].cond == ROX_COND_CROSS && !trig[0]
			&& s.timer[0] == 16'h0001 && s.sub[0] == 24'(MS_CYCLES - 1);
	endsequence

	a_up_edge: assert property (s_edge_up0 |=> s.timer[0] == $past(dur_eff[0]) && s.refl[0])
		else $error("upward crossing did not start the pulse");
	a_down_edge: assert property (s_edge_dn0 |=> s.timer[0] == $past(dur_eff[0]) && s.refl[0])
		else $error("downward crossing did not start the pulse");
	a_retrigger_restart: assert property (trig[0] && s.timer[0] != 16'h0000 |=> s.sub[0] == 24'h00_0000
		&& s.timer[0] == $past(dur_eff[0]))
		else $error("retrigger did not restart the pulse");
	a_pulse_end: assert property (s_last_ms0 |=> s.timer[0] == 16'h0000 && !s.refl[0] ##1 !s.refl[0])
		else $error("pulse did not end after its last millisecond");
	a_suspend_pulse: assert property (s.ctrl_sus ##0 s_last_ms0 |=> !s.refl[0] && !s.drv[0])
		else $error("pulse under suspension did not finish");
	a_above_track: assert property (s_run_cmp |=> s.above == $past(ab_now))
		else $error("above-level bits do not follow the counter");
	a_suspend_hold: assert property (s.ctrl_en && s.ctrl_sus |=> $stable(s.above) && (s.drv & ~$past(s.drv)) == 4'h0)
		else $error("status changed while suspended");
	a_drive_gated: assert property (s_run_cmp |=> s.drv == ($past(s.gate) & s.refl))
		else $error("driven outputs differ from enable and condition");
	a_stop_mode: assert property (s_run_cmp ##0 s.cfg[1].cond == ROX_COND_STOP
		|=> s.refl[1] == ($past(s.cfg[1].run_sel) ? $past(counter_running) : !$past(counter_running)))
		else $error("counter stop condition wrong");
	a_zone_within: assert property (s_run_cmp ##0 s.cfg[2].cond == ROX_COND_WITHIN
		|=> s.refl[2] == |($past(s.cfg[2].zone) & zones($past(ab_now))))
		else $error("counter zone condition wrong");
	a_zone_capture: assert property (s_run_cmp ##0 s.cfg[3].cond == ROX_COND_CAPTURE
		|=> s.refl[3] == |($past(s.cfg[3].zone) & zones($past(cab_now))))
		else $error("capture zone condition wrong");
	a_level_hold: assert property (!(preset_cond && !s.preset_prev) |=> $stable(s.lvl))
		else $error("levels changed without a preset rise");
	a_level_load: assert property (preset_cond && !s.preset_prev |=> s.lvl == $past(s.stage))
		else $error("preset rise did not load the levels");
	a_compare_off: assert property (!s.ctrl_en |=> s.refl == 4'h0 && s.above == 4'h0 && s.drv == 4'h0)
		else $error("status not cleared with compare off");

	// The bus answers one cycle after a request is taken, whatever the compare core is doing.
	sequence s_write_taken;
		axil_req.awvalid && s.rsp.awready && axil_req.wvalid && s.rsp.wready;
	endsequence
	a_write_answer: assert property (s_write_taken |=> s.rsp.bvalid && !s.rsp.awready && !s.rsp.wready)
		else $error("write was not answered in one cycle");
	a_read_answer: assert property (axil_req.arvalid && s.rsp.arready |=> s.rsp.rvalid && !s.rsp.arready)
		else $error("read was not answered in one cycle");
	a_event_set: assert property ($rose(s.refl[1]) |-> s.irq_st[1])
		else $error("rising condition did not set its status bit");
endmodule // rox_top

`default_nettype wire

// ==== test/rox_host.sv ====
// AXI4-Lite host model that writes enables, levels and settings and reads status words.
// Assumes the bench issues one transfer at a time; a transfer gives up after 200 cycles.
`timescale 1ns/1ps
`default_nettype none
module rox_host (
	input  wire logic                      ref_clk,
	output var  rox_pkg::rox_axil_req_type axil_req,
	input  wire rox_pkg::rox_axil_rsp_type axil_rsp
);
	import rox_pkg::*;
	int tmo = 0;
	initial axil_req = '0;
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic [1:0] r);
		int n;
		n = 0;
		axil_req.awaddr  <= a;
		axil_req.wdata   <= d;
		axil_req.wstrb   <= 4'hF;
		axil_req.araddr  <= a;
		axil_req.awvalid <= w;
		axil_req.wvalid  <= w;
		axil_req.bready  <= w;
		axil_req.arvalid <= !w;
		axil_req.rready  <= !w;
		do begin
			@(posedge ref_clk);
			n++;
			if (axil_rsp.awready)
				axil_req.awvalid <= 1'b0;
			if (axil_rsp.wready)
				axil_req.wvalid <= 1'b0;
			if (axil_rsp.arready)
				axil_req.arvalid <= 1'b0;
		end while ((w ? axil_rsp.bvalid : axil_rsp.rvalid) !== 1'b1 && n < 200);
		q = axil_rsp.rdata;
		r = w ? axil_rsp.bresp : axil_rsp.rresp;
		axil_req.bready <= 1'b0;
		axil_req.rready <= 1'b0;
		// Released payload is inverted, so a slave that samples it late reads a wrong value.
		axil_req.awaddr <= ~a;
		axil_req.wdata  <= ~d;
		axil_req.araddr <= ~a;
		if (n >= 200)
			tmo++;
		@(posedge ref_clk);
	endtask
endmodule // rox_host
`default_nettype wire

// ==== test/rox_top_tb.sv ====
// Self-checking bench for the reflex output compare block, with a model of levels, zones and pulses.
// Assumes rox_host owns the register bus and that one millisecond is shortened to MSC cycles.
`timescale 1ns/1ps
`default_nettype none
module rox_top_tb;
	import rox_pkg::*;
	localparam int MSC = 4;
	logic             ref_clk = 1'b0;
	logic             srst    = 1'b1;
	logic             clk_en  = 1'b1;
	logic [31:0]      cnt     = '0;
	logic [31:0]      cap     = '0;
	logic             run     = 1'b0;
	logic             pre     = 1'b0;
	logic [3:0]       phys_out;
	logic             irq;
	rox_axil_req_type req;
	rox_axil_rsp_type rsp;
	int               err_total  = 0;
	int               num_checks = 0;
	int               lv[4]      = '{default: 0};
	int               st[4];
	always #2.5 ref_clk = ~ref_clk;
	rox_top #(.MS_CYCLES(MSC)) rox_top_inst (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .axil_req(req),
		.axil_rsp(rsp), .counter_value(cnt), .capture_value(cap), .counter_running(run), .preset_cond(pre),
		.phys_out(phys_out), .irq(irq));
	rox_host rox_host_inst (.ref_clk(ref_clk), .axil_req(req), .axil_rsp(rsp));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = ROX_RESP_OKAY);
		logic [31:0] q;
		logic [1:0]  r;
		rox_host_inst.xfer(1'b1, a, d, q, r);
		chk(32'(r), 32'(er));
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = ROX_RESP_OKAY);
		logic [31:0] q;
		logic [1:0]  r;
		rox_host_inst.xfer(1'b0, a, 32'h0000_0000, q, r);
		chk(q, e);
		chk(32'(r), 32'(er));
	endtask
	// Model of the above-level byte against the active levels.
	function automatic logic [3:0] abv(input int v);
		for (int k = 0; k < 4; k++)
			abv[k] = v > lv[k];
	endfunction
	// A settle time first, so a pulse left over from the previous setting has ended.
	task automatic xrun(input int a, input int b, input logic re, input int e);
		int n;
		n = 0;
		cnt <= a;
		repeat (20) @(posedge ref_clk);
		for (int j = 0; j < 40; j++) begin
			if (j == 0 || j == 6)
				cnt <= b;
			if (re && j == 3)
				cnt <= a;
			@(posedge ref_clk);
			if (phys_out[0] === 1'b1)
				n++;
		end
		chk(32'(n), 32'(e));
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		for (int i = 0; i < 20000 && rox_host_inst.tmo == 0; i++)
			@(posedge ref_clk);
		err_total++;
		end_sim();
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		int         v;
		int         cp;
		logic       rn;
		logic [3:0] g;
		logic [3:0] e;
		logic [2:0] c[4];
		logic [4:0] z[4];
		logic       rs[4];
		logic [2:0] ct[4];
		void'($urandom(32'h0000_ad19));
		ct = '{ROX_COND_OFF, ROX_COND_WITHIN, ROX_COND_CAPTURE, ROX_COND_STOP};
		repeat (12) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		for (int i = 0; i < 20; i++)
			if (i == 7 || (i > 11 && i < 16))
				rc(8'(4 * i), 32'h0000_0000, ROX_RESP_SLVERR);
			else
				rc(8'(4 * i), (i > 7 && i < 12) ? {ROX_DUR_RESET, 16'h0000} : 32'h0000_0000);
		wr(ROX_REG_REFL, 32'h0000_000F);
		rc(ROX_REG_REFL, 32'h0000_0000);
		wr(8'h30, 32'hFFFF_FFFF, ROX_RESP_SLVERR);
		$display("test reset done");
		wr(ROX_REG_CTRL, 32'h0000_0001);
		wr(ROX_REG_GATE, 32'h0000_000F);
		for (int k = 0; k < 4; k++) begin
			st[k] = 200 * k - 300 + int'($urandom % 50);
			wr({ROX_REG_LVL_PAGE, 2'(k), 2'b00}, st[k]);
		end
		repeat (3) @(posedge ref_clk);
		rc(ROX_REG_ABOVE, 32'(abv(0)));
		pre <= 1'b1;
		repeat (3) @(posedge ref_clk);
		lv = st;
		pre <= 1'b0;
		rc(ROX_REG_ABOVE, 32'(abv(0)));
		$display("test levels done");
		for (int t = 0; t < 24; t++) begin
			v = lv[$urandom % 4] + int'($urandom % 5) - 2;
			cp = int'($urandom % 900) - 450;
			rn = 1'($urandom);
			g = 4'($urandom);
			cnt <= v;
			cap <= cp;
			run <= rn;
			for (int k = 0; k < 4; k++) begin
				c[k] = ct[$urandom % 4];
				z[k] = 5'($urandom);
				rs[k] = 1'($urandom);
				case (c[k])
					ROX_COND_WITHIN: e[k] = z[k][$countones(abv(v))];
					ROX_COND_CAPTURE: e[k] = z[k][$countones(abv(cp))];
					ROX_COND_STOP: e[k] = rs[k] ? rn : !rn;
					default: e[k] = 1'b0;
				endcase
				wr({ROX_REG_CFG_PAGE, 2'(k), 2'b00}, {ROX_DUR_RESET, 4'h0, rs[k], 3'b000, z[k], c[k]});
			end
			wr(ROX_REG_GATE, 32'(g));
			repeat (4) @(posedge ref_clk);
			rc(ROX_REG_REFL, 32'(e));
			rc(ROX_REG_ABOVE, 32'(abv(v)));
			rc(ROX_REG_DRV, 32'(e & g));
			chk(32'(phys_out), 32'(e & g));
		end
		$display("test zones done");
		wr(ROX_REG_GATE, 32'h0000_000F);
		for (int k = 1; k < 4; k++)
			wr({ROX_REG_CFG_PAGE, 2'(k), 2'b00}, 32'h0000_0000);
		for (int k = 0; k < 8; k++) begin
			wr(8'h20, {16'h0002, 5'h00, 1'(k), 2'(k / 2), 5'h00, ROX_COND_CROSS});
			v = k % 2 ? -7 : 7;
			xrun(lv[k / 2] + v, lv[k / 2] - v, 1'b0, 2 * MSC);
			xrun(lv[k / 2] - v, lv[k / 2] + v, 1'b0, 0);
		end
		xrun(lv[3] - 7, lv[3] + 7, 1'b1, 6 + 2 * MSC);
		$display("test cross done");
		wr(8'h20, {16'h0004, 5'h00, 1'b1, 2'h0, 5'h00, ROX_COND_CROSS});
		wr(8'h24, {ROX_DUR_RESET, 4'h0, 1'b0, 3'h0, 5'h02, ROX_COND_WITHIN});
		cnt <= lv[0] - 7;
		repeat (30) @(posedge ref_clk);
		cnt <= lv[0] + 7;
		repeat (3) @(posedge ref_clk);
		wr(ROX_REG_CTRL, 32'h0000_0003);
		cnt <= lv[3] + 7;
		chk(32'(phys_out), 32'h0000_0003);
		repeat (20) @(posedge ref_clk);
		chk(32'(phys_out), 32'h0000_0002);
		rc(ROX_REG_REFL, 32'h0000_0002);
		rc(ROX_REG_ABOVE, 32'h0000_0001);
		rc(ROX_REG_DRV, 32'h0000_0002);
		$display("test suspend done");
		wr(ROX_REG_CTRL, 32'h0000_0001);
		wr(ROX_REG_IRQ_ST, 32'h0000_000F);
		rc(ROX_REG_IRQ_ST, 32'h0000_0000);
		chk(32'(irq), 32'h0000_0000);
		cnt <= lv[0] + 7;
		repeat (4) @(posedge ref_clk);
		rc(ROX_REG_IRQ_ST, 32'h0000_0002);
		chk(32'(irq), 32'h0000_0000);
		wr(ROX_REG_IRQ_MASK, 32'h0000_0002);
		repeat (2) @(posedge ref_clk);
		chk(32'(irq), 32'h0000_0001);
		wr(ROX_REG_IRQ_ST, 32'h0000_0002);
		repeat (2) @(posedge ref_clk);
		chk(32'(irq), 32'h0000_0000);
		$display("test interrupt done");
		clk_en <= 1'b0;
		cnt <= lv[3] + 7;
		repeat (5) @(posedge ref_clk);
		chk(32'(phys_out), 32'h0000_0002);
		clk_en <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chk(32'(phys_out), 32'h0000_0000);
		$display("test clock enable done");
		srst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		chk(32'(phys_out), 32'h0000_0000);
		rc(ROX_REG_CTRL, 32'h0000_0000);
		rc(8'h20, {ROX_DUR_RESET, 16'h0000});
		$display("test reset again done");
		end_sim();
	end
endmodule // rox_top_tb
`default_nettype wire
